// *** shared/cgts_pkg.sv ***
// constants and types for the clock generator trim and status block
package cgts_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_REF_TRIM = 8'h00;
    localparam logic [7:0] OFF_CLK_STATUS_CTRL = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    // status and control field positions
    localparam int BIT_LOCK_LOST = 7;
    localparam int BIT_LOCK = 6;
    localparam int BIT_LOOP_SRC = 5;
    localparam int BIT_REF_SRC = 4;
    localparam int BIT_MODE_LO = 2;
    localparam int BIT_OSC_READY = 1;
    localparam int BIT_FINE = 0;
    // reset values
    localparam logic [7:0] RST_REF_TRIM = 8'h80;
    localparam logic RST_FINE = 1'b0;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // default oscillator start-up count in system clocks
    localparam int OSC_INIT_CYCLES_DEF = 1024;
    // clock source select codes
    localparam logic [1:0] CLKSRC_LOOP = 2'h0;
    localparam logic [1:0] CLKSRC_INT = 2'h1;
    localparam logic [1:0] CLKSRC_EXT = 2'h2;
    // clock mode status codes
    localparam logic [1:0] MODEST_FLL = 2'h0;
    localparam logic [1:0] MODEST_INT = 2'h1;
    localparam logic [1:0] MODEST_EXT = 2'h2;
    localparam logic [1:0] MODEST_PLL = 2'h3;
    // operating modes reported by the mode state machine
    typedef enum logic [3:0] {
        FLL_ENGAGED_INT_MODE = 4'h0,
        FLL_ENGAGED_EXT_MODE = 4'h1,
        FLL_BYPASS_INT_MODE = 4'h2,
        FLL_BYPASS_EXT_MODE = 4'h3,
        PLL_ENGAGED_EXT_MODE = 4'h4,
        PLL_BYPASS_EXT_MODE = 4'h5,
        LOWPOWER_BYPASS_INT_MODE = 4'h6,
        LOWPOWER_BYPASS_EXT_MODE = 4'h7,
        STOP_MODE = 4'h8
    } cgts_mode_t;
    // lock tracker states
    typedef enum logic [2:0] {
        LK_IDLE = 3'h1,
        LK_SEEK = 3'h2,
        LK_LOCKED = 3'h4
    } cgts_lock_t;
endpackage

// *** verilog/cgts_top.sv ***
// clock generator trim, lock tracking and status registers with apb access
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module cgts_top
    import cgts_pkg::*;
#(
    parameter int OSC_INIT_CYCLES = OSC_INIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // control bits from the rest of the generator
    input wire logic REF_INTERNAL_SELECT,
    input wire logic LOOP_PATH_SELECT,
    input wire logic [1:0] CLK_SOURCE_SELECT,
    input wire logic [2:0] REF_DIVIDER,
    input wire logic [3:0] VCO_MULT_SELECT,
    input wire logic EXT_OSC_REQUEST,
    input wire logic EXT_REF_ENABLE,
    input wire logic [3:0] MODE_STATE,
    // loop lock detector
    input wire logic LOOP_IN_LOCK,
    input wire logic LOOP_OUT_OF_TOL,
    // trim and enables toward the analog parts
    output logic [7:0] REF_PERIOD_COARSE,
    output logic REF_PERIOD_FINE,
    output logic [8:0] REF_PERIOD_CODE,
    output logic FLL_ENABLE,
    output logic PLL_ENABLE,
    output logic XTAL_OSC_REQ,
    output logic EXT_CLK_REQ,
    // status and interrupt
    output logic LOCK_STATUS,
    output logic IRQ
);

    localparam int CW = $clog2(OSC_INIT_CYCLES + 1);
    localparam logic [CW-1:0] INIT_LAST = CW'(OSC_INIT_CYCLES);

    if (OSC_INIT_CYCLES < 1) begin : g_chk
        $error("OSC_INIT_CYCLES must be at least one");
    end

    function automatic logic is_ext_mode(input logic [3:0] m);
        return m == FLL_ENGAGED_EXT_MODE || m == FLL_BYPASS_EXT_MODE ||
            m == PLL_ENGAGED_EXT_MODE || m == PLL_BYPASS_EXT_MODE ||
            m == LOWPOWER_BYPASS_EXT_MODE;
    endfunction

    function automatic logic is_int_mode(input logic [3:0] m);
        return m == FLL_ENGAGED_INT_MODE || m == FLL_BYPASS_INT_MODE ||
            m == LOWPOWER_BYPASS_INT_MODE;
    endfunction

    function automatic logic is_lowpower(input logic [3:0] m);
        return m == LOWPOWER_BYPASS_INT_MODE || m == LOWPOWER_BYPASS_EXT_MODE;
    endfunction

    // apb decode
    logic acc;
    logic wr_done;
    logic hit_trim;
    logic hit_sc;
    logic hit_mask;
    logic hit_any;
    assign acc = PSEL && PENABLE && !PREADY;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    assign hit_trim = PADDR == OFF_REF_TRIM;
    assign hit_sc = PADDR == OFF_CLK_STATUS_CTRL;
    assign hit_mask = PADDR == OFF_IRQ_MASK;
    assign hit_any = hit_trim || hit_sc || hit_mask;

    // software registers
    logic [7:0] trim_reg, trim_next;
    logic fine_reg, fine_next;
    logic [7:0] mask_reg, mask_next;
    logic lost_reg, lost_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic err_reg, err_next;

    // synchroniser stages for selects
    logic [3:0] sync1_reg, sync1_next;
    logic [3:0] sync2_reg, sync2_next;

    // change tracking
    logic ref_sel_prev_reg, loop_sel_prev_reg;
    logic [2:0] div_prev_reg;
    logic [7:0] trim_prev_reg;
    logic [3:0] vco_prev_reg;
    logic stop_prev_reg, lowp_prev_reg;

    // lock tracker and oscillator
    cgts_lock_t lock_reg, lock_next;
    logic [CW-1:0] init_cnt_reg, init_cnt_next;
    logic osc_rdy_reg, osc_rdy_next;

    // outputs
    logic fll_en_reg, fll_en_next;
    logic pll_en_reg, pll_en_next;
    logic irq_reg, irq_next;
    logic xtal_reg, extclk_reg;
    logic lock_out_reg, lock_out_next;

    logic det_en;
    logic cfg_change;
    logic in_stop;
    logic in_lowp;
    logic lock_loss;
    logic [1:0] mode_st;
    logic [7:0] sc_view;

    assign in_stop = MODE_STATE == STOP_MODE;
    assign in_lowp = is_lowpower(MODE_STATE);

    // loop enables
    always_comb begin
        fll_en_next = !LOOP_PATH_SELECT && !in_stop && !in_lowp;
        pll_en_next = LOOP_PATH_SELECT && !in_stop && !in_lowp;
    end

    assign det_en = fll_en_reg || pll_en_reg;

    assign cfg_change = (REF_INTERNAL_SELECT != ref_sel_prev_reg) ||
        (LOOP_PATH_SELECT != loop_sel_prev_reg) ||
        (REF_DIVIDER != div_prev_reg) ||
        ((trim_reg != trim_prev_reg) &&
            (MODE_STATE == FLL_ENGAGED_INT_MODE || MODE_STATE == FLL_BYPASS_INT_MODE)) ||
        ((VCO_MULT_SELECT != vco_prev_reg) &&
            (MODE_STATE == PLL_ENGAGED_EXT_MODE || MODE_STATE == PLL_BYPASS_EXT_MODE));

    assign lock_loss = lock_reg == LK_LOCKED && det_en && LOOP_OUT_OF_TOL;
    assign lock_out_next = lock_next == LK_LOCKED;

    // lock tracker
    always_comb begin
        lock_next = lock_reg;
        unique case (lock_reg)
            LK_IDLE: begin
                if (det_en && !in_lowp && !in_stop) begin
                    lock_next = LK_SEEK;
                end
            end
            LK_SEEK: begin
                if (!det_en || in_lowp || in_stop) begin
                    lock_next = LK_IDLE;
                end else if (LOOP_IN_LOCK && !cfg_change) begin
                    lock_next = LK_LOCKED;
                end
            end
            LK_LOCKED: begin
                if (in_stop && !stop_prev_reg) begin
                    lock_next = LK_IDLE;
                end else if (in_lowp && !lowp_prev_reg) begin
                    lock_next = LK_IDLE;
                end else if (!det_en) begin
                    lock_next = LK_IDLE;
                end else if (cfg_change || LOOP_OUT_OF_TOL) begin
                    lock_next = LK_SEEK;
                end
            end
            default: begin
                lock_next = LK_IDLE;
            end
        endcase
    end

    // oscillator ready
    always_comb begin
        init_cnt_next = init_cnt_reg;
        osc_rdy_next = osc_rdy_reg;
        if (!EXT_OSC_REQUEST || (is_int_mode(MODE_STATE) && !EXT_REF_ENABLE)) begin
            init_cnt_next = '0;
            osc_rdy_next = 1'b0;
        end else if (EXT_REF_ENABLE || is_ext_mode(MODE_STATE)) begin
            if (init_cnt_reg == INIT_LAST) begin
                osc_rdy_next = 1'b1;
            end else begin
                init_cnt_next = init_cnt_reg + CW'(1);
            end
        end
    end

    always_comb begin
        sync1_next = {REF_INTERNAL_SELECT, LOOP_PATH_SELECT, CLK_SOURCE_SELECT};
        sync2_next = sync1_reg;
    end

    always_comb begin
        unique case (sync2_reg[1:0])
            CLKSRC_INT: mode_st = MODEST_INT;
            CLKSRC_EXT: mode_st = MODEST_EXT;
            default: mode_st = sync2_reg[2] ? MODEST_PLL : MODEST_FLL;
        endcase
    end

    always_comb begin
        sc_view = '0;
        sc_view[BIT_LOCK_LOST] = lost_reg;
        sc_view[BIT_LOCK] = lock_reg == LK_LOCKED;
        sc_view[BIT_LOOP_SRC] = sync2_reg[2];
        sc_view[BIT_REF_SRC] = sync2_reg[3];
        sc_view[BIT_MODE_LO +: 2] = mode_st;
        sc_view[BIT_OSC_READY] = osc_rdy_reg;
        sc_view[BIT_FINE] = fine_reg;
    end

    // register file and bus answer
    always_comb begin
        trim_next = trim_reg;
        fine_next = fine_reg;
        mask_next = mask_reg;
        lost_next = lost_reg;
        rdata_next = rdata_reg;
        ready_next = acc;
        err_next = acc && !hit_any;
        if (acc && !PWRITE) begin
            rdata_next = RST_RDATA;
            if (hit_trim) begin
                rdata_next[7:0] = trim_reg;
            end else if (hit_sc) begin
                rdata_next[7:0] = sc_view;
            end else if (hit_mask) begin
                rdata_next[7:0] = mask_reg;
            end
        end
        if (wr_done && hit_trim) begin
            trim_next = PWDATA[7:0];
        end
        if (wr_done && hit_sc) begin
            fine_next = PWDATA[BIT_FINE];
            if (PWDATA[BIT_LOCK_LOST]) begin
                lost_next = 1'b0;
            end
        end
        if (wr_done && hit_mask) begin
            mask_next = PWDATA[7:0];
        end
        // set lock lost, wins over clear
        if (lock_loss) begin
            lost_next = 1'b1;
        end
    end

    assign irq_next = lost_next && mask_next[BIT_LOCK_LOST];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            trim_reg <= RST_REF_TRIM;
            fine_reg <= RST_FINE;
            mask_reg <= RST_IRQ_MASK;
            lost_reg <= 1'b0;
            rdata_reg <= RST_RDATA;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            sync1_reg <= '0;
            sync2_reg <= '0;
            ref_sel_prev_reg <= 1'b0;
            loop_sel_prev_reg <= 1'b0;
            div_prev_reg <= '0;
            trim_prev_reg <= RST_REF_TRIM;
            vco_prev_reg <= '0;
            stop_prev_reg <= 1'b0;
            lowp_prev_reg <= 1'b0;
            lock_reg <= LK_IDLE;
            init_cnt_reg <= '0;
            osc_rdy_reg <= 1'b0;
            fll_en_reg <= 1'b0;
            pll_en_reg <= 1'b0;
            irq_reg <= 1'b0;
            lock_out_reg <= 1'b0;
            xtal_reg <= 1'b0;
            extclk_reg <= 1'b0;
        end else begin
            trim_reg <= trim_next;
            fine_reg <= fine_next;
            mask_reg <= mask_next;
            lost_reg <= lost_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            ref_sel_prev_reg <= REF_INTERNAL_SELECT;
            loop_sel_prev_reg <= LOOP_PATH_SELECT;
            div_prev_reg <= REF_DIVIDER;
            trim_prev_reg <= trim_reg;
            vco_prev_reg <= VCO_MULT_SELECT;
            stop_prev_reg <= in_stop;
            lowp_prev_reg <= in_lowp;
            lock_reg <= lock_next;
            init_cnt_reg <= init_cnt_next;
            osc_rdy_reg <= osc_rdy_next;
            fll_en_reg <= fll_en_next;
            pll_en_reg <= pll_en_next;
            irq_reg <= irq_next;
            lock_out_reg <= lock_out_next;
            xtal_reg <= EXT_OSC_REQUEST;
            extclk_reg <= !EXT_OSC_REQUEST;
        end
    end

    // output drive
    assign PRDATA = rdata_reg;
    assign PREADY = ready_reg;
    assign PSLVERR = err_reg;
    assign REF_PERIOD_COARSE = trim_reg;
    assign REF_PERIOD_FINE = fine_reg;
    assign REF_PERIOD_CODE = {trim_reg, fine_reg};
    assign FLL_ENABLE = fll_en_reg;
    assign PLL_ENABLE = pll_en_reg;
    assign XTAL_OSC_REQ = xtal_reg;
    assign EXT_CLK_REQ = extclk_reg;
    assign LOCK_STATUS = lock_out_reg;
    assign IRQ = irq_reg;

endmodule

// *** testbench/cgts_assertions.sv ***
// port checks for the trim and status block
`timescale 1ns/1ps
module cgts_checker
    import cgts_pkg::*;
(
    // clock and reset
    input logic CLK_SYS,
    input logic RST_B,
    // apb
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    // control inputs
    input logic REF_INTERNAL_SELECT,
    input logic LOOP_PATH_SELECT,
    input logic [1:0] CLK_SOURCE_SELECT,
    input logic [2:0] REF_DIVIDER,
    input logic [3:0] VCO_MULT_SELECT,
    input logic EXT_OSC_REQUEST,
    input logic EXT_REF_ENABLE,
    input logic [3:0] MODE_STATE,
    input logic LOOP_IN_LOCK,
    input logic LOOP_OUT_OF_TOL,
    // outputs
    input logic [7:0] REF_PERIOD_COARSE,
    input logic REF_PERIOD_FINE,
    input logic [8:0] REF_PERIOD_CODE,
    input logic FLL_ENABLE,
    input logic PLL_ENABLE,
    input logic XTAL_OSC_REQ,
    input logic EXT_CLK_REQ,
    input logic LOCK_STATUS,
    input logic IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    sequence apb_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence one_pulse;
        PREADY ##1 !PREADY;
    endsequence
    apb_answer_a:
        assert property (apb_access |=> one_pulse) else $error("apb answer wrong");
    err_with_ready_a:
        assert property (PSLVERR |-> PREADY) else $error("error without ready");
    read_upper_zero_a:
        assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
    trim_code_a:
        assert property (REF_PERIOD_CODE == {REF_PERIOD_COARSE, REF_PERIOD_FINE})
        else $error("trim code mismatch");
    osc_request_a:
        assert property ($past(RST_B) |-> XTAL_OSC_REQ == $past(EXT_OSC_REQUEST)
            && EXT_CLK_REQ == !$past(EXT_OSC_REQUEST)) else $error("osc request wrong");
    loop_excl_a:
        assert property ($past(RST_B) |-> !(FLL_ENABLE && $past(LOOP_PATH_SELECT))
            && !(PLL_ENABLE && !$past(LOOP_PATH_SELECT))) else $error("loop enable wrong");
    lock_cfg_drop_a:
        assert property (LOCK_STATUS && ($changed(REF_INTERNAL_SELECT)
            || $changed(LOOP_PATH_SELECT) || $changed(REF_DIVIDER)) |-> ##[1:3] !LOCK_STATUS)
        else $error("lock kept after change");
    lock_stop_a:
        assert property ((MODE_STATE == 4'h8)[*3] |-> !LOCK_STATUS)
        else $error("lock in stop");
    lock_lowpwr_a:
        assert property ((MODE_STATE == 4'h6 || MODE_STATE == 4'h7)[*3] |-> !LOCK_STATUS)
        else $error("lock in low power");
    lock_noloop_a:
        assert property ((!FLL_ENABLE && !PLL_ENABLE)[*3] |-> !LOCK_STATUS)
        else $error("lock with loops off");
    irq_cause_a:
        assert property ($rose(IRQ) |-> $past(LOOP_OUT_OF_TOL) || $past(LOOP_OUT_OF_TOL, 2)
            || $past(PSEL) || $past(PSEL, 2) || $past(PSEL, 3)) else $error("irq without cause");
endmodule
bind cgts_top cgts_checker u_chk (.*);

// *** testbench/clock_gen_trim_and_status_tb.sv ***
// self-checking bench for the trim and status block
`timescale 1ns/1ps
module clock_gen_trim_and_status_tb;
    import cgts_pkg::*;
    localparam int OSC_N = 4;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic REF_INTERNAL_SELECT = 1'b1, LOOP_PATH_SELECT = 1'b0, EXT_OSC_REQUEST = 1'b0;
    logic EXT_REF_ENABLE = 1'b0, LOOP_IN_LOCK = 1'b0, LOOP_OUT_OF_TOL = 1'b0;
    logic [1:0] CLK_SOURCE_SELECT = 2'h0;
    logic [2:0] REF_DIVIDER = 3'h0;
    logic [3:0] VCO_MULT_SELECT = 4'h1, MODE_STATE = 4'h0;
    logic PREADY, PSLVERR, REF_PERIOD_FINE, FLL_ENABLE, PLL_ENABLE, err;
    logic XTAL_OSC_REQ, EXT_CLK_REQ, LOCK_STATUS, IRQ;
    logic [7:0] REF_PERIOD_COARSE;
    logic [7:0] seed = 8'h08;
    logic [8:0] REF_PERIOD_CODE;
    int n_mismatch = 0, check_count = 0, i;
    int m_trim = 8'h80, m_fine = 0, m_lost = 0, m_lock = 0, m_osc = 0;
    always #4 CLK_SYS = ~CLK_SYS;
    cgts_top #(.OSC_INIT_CYCLES(OSC_N)) u_dut (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] st();
        int md;
        md = (CLK_SOURCE_SELECT == 2'h1) ? 1 : (CLK_SOURCE_SELECT == 2'h2) ? 2 : 0;
        md = (md == 0 && LOOP_PATH_SELECT) ? 3 : md;
        return {24'h0, 1'(m_lost), 1'(m_lock), LOOP_PATH_SELECT, REF_INTERNAL_SELECT,
            2'(md), 1'(m_osc), 1'(m_fine)};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        for (n = 0; n < 20 && PREADY !== 1'b1; n++) @(posedge CLK_SYS);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n == 20) begin
            n_mismatch++;
            $display("Error at %0t: bus answer timed out", $time);
            close_out();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_lock(input logic v);
        int n;
        for (n = 0; n < 40 && LOCK_STATUS !== v; n++) @(posedge CLK_SYS);
        if (n == 40) begin
            n_mismatch++;
            $display("Error at %0t: lock wait timed out", $time);
            close_out();
        end
    endtask
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        rdc(OFF_REF_TRIM, 32'h80);
        rdc(OFF_CLK_STATUS_CTRL, st());
        rdc(OFF_IRQ_MASK, 32'h0);
        $display("reset test done");
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            m_trim = seed;
            m_fine = seed[0];
            apb(1'b1, OFF_REF_TRIM, {24'h0, seed});
            apb(1'b1, OFF_CLK_STATUS_CTRL, {31'h0, seed[0]});
            rdc(OFF_REF_TRIM, m_trim);
            chk(REF_PERIOD_CODE, {seed, seed[0]});
        end
        apb(1'b1, 8'h0C, 32'hFF);
        chk(err, 1'b1);
        rdc(8'h0C, 32'h0);
        rdc(OFF_REF_TRIM, m_trim);
        $display("trim test done");
        for (i = 0; i < 8; i++) begin
            @(posedge CLK_SYS);
            CLK_SOURCE_SELECT <= 2'(i);
            LOOP_PATH_SELECT <= i[2];
            REF_INTERNAL_SELECT <= ~i[0];
            repeat (4) @(posedge CLK_SYS);
            rdc(OFF_CLK_STATUS_CTRL, st());
        end
        $display("source test done");
        @(posedge CLK_SYS);
        LOOP_PATH_SELECT <= 1'b0;
        REF_INTERNAL_SELECT <= 1'b1;
        CLK_SOURCE_SELECT <= 2'h0;
        LOOP_IN_LOCK <= 1'b1;
        wait_lock(1'b1);
        m_lock = 1;
        rdc(OFF_CLK_STATUS_CTRL, st());
        apb(1'b1, OFF_REF_TRIM, 32'h11);
        wait_lock(1'b0);
        wait_lock(1'b1);
        LOOP_OUT_OF_TOL <= 1'b1;
        @(posedge CLK_SYS);
        LOOP_OUT_OF_TOL <= 1'b0;
        m_lost = 1;
        repeat (3) @(posedge CLK_SYS);
        wait_lock(1'b1);
        chk(IRQ, 1'b0);
        rdc(OFF_CLK_STATUS_CTRL, st());
        apb(1'b1, OFF_IRQ_MASK, 32'h80);
        repeat (2) @(posedge CLK_SYS);
        chk(IRQ, 1'b1);
        rdc(OFF_IRQ_MASK, 32'h80);
        apb(1'b1, OFF_CLK_STATUS_CTRL, 32'(m_fine));
        rdc(OFF_CLK_STATUS_CTRL, st());
        apb(1'b1, OFF_CLK_STATUS_CTRL, 32'h80 | 32'(m_fine));
        m_lost = 0;
        rdc(OFF_CLK_STATUS_CTRL, st());
        chk(IRQ, 1'b0);
        $display("lock lost test done");
        REF_DIVIDER <= 3'h1;
        wait_lock(1'b0);
        wait_lock(1'b1);
        MODE_STATE <= 4'h8;
        wait_lock(1'b0);
        m_lock = 0;
        rdc(OFF_CLK_STATUS_CTRL, st());
        MODE_STATE <= 4'h0;
        wait_lock(1'b1);
        MODE_STATE <= 4'h6;
        wait_lock(1'b0);
        repeat (4) @(posedge CLK_SYS);
        chk(LOCK_STATUS, 1'b0);
        MODE_STATE <= 4'h0;
        wait_lock(1'b1);
        m_lock = 1;
        $display("mode test done");
        EXT_OSC_REQUEST <= 1'b1;
        EXT_REF_ENABLE <= 1'b1;
        repeat (OSC_N + 4) @(posedge CLK_SYS);
        m_osc = 1;
        rdc(OFF_CLK_STATUS_CTRL, st());
        chk({XTAL_OSC_REQ, EXT_CLK_REQ}, 2'b10);
        EXT_REF_ENABLE <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        m_osc = 0;
        rdc(OFF_CLK_STATUS_CTRL, st());
        $display("oscillator test done");
        close_out();
    end
endmodule
